/* rtl/fpc_pkg.sv */
// package: opcodes, command kinds, request carrier and timing counts for the flash command host
package fpc_pkg;

  // ****************************************
  // opcodes sent on the serial bus
  // ****************************************
  localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_DUAL_IN_PAGE_PROGRAM = 8'hA2;
  localparam logic [7:0] OPC_QUAD_IN_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OPC_ERASE_64K_BLOCK = 8'hD8;
  localparam logic [7:0] OPC_OP_SUSPEND = 8'h75;
  localparam logic [7:0] OPC_OP_SUSPEND_ALT = 8'hB0;
  localparam logic [7:0] OPC_OP_RESUME = 8'h7A;
  localparam logic [7:0] OPC_OP_RESUME_ALT = 8'h30;
  localparam logic [7:0] OPC_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OPC_VOLATILE_STATUS_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OPC_SINGLE_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] OPC_SINGLE_BLOCK_UNLOCK = 8'h39;
  localparam logic [7:0] OPC_BLOCK_LOCK_QUERY = 8'h3C;
  localparam logic [7:0] OPC_BLOCK_LOCK_QUERY_ALT = 8'h3D;
  localparam logic [7:0] OPC_ALL_BLOCKS_LOCK = 8'h7E;
  localparam logic [7:0] OPC_ALL_BLOCKS_UNLOCK = 8'h98;
  localparam logic [7:0] OPC_SECURE_AREA_ERASE = 8'h44;
  localparam logic [7:0] OPC_SECURE_AREA_PROGRAM = 8'h42;

  // ****************************************
  // framing and timing counts (clock_i cycles)
  // ****************************************
  localparam int ADDR_BYTES = 3;
  localparam int SCK_HALF_CYCLES = 4;
  localparam logic [3:0] CS_SETUP_CYCLES = 4'h2;
  localparam logic [3:0] CS_HOLD_CYCLES = 4'h2;
  localparam logic [3:0] CS_GAP_CYCLES = 4'h8;
  localparam logic [7:0] LOCK_BYTE_RESET = 8'h00;

  // ****************************************
  // commands and request carrier
  // ****************************************
  typedef enum logic [3:0] {
    CMD_PAGE_PROGRAM,
    CMD_DUAL_IN_PAGE_PROGRAM,
    CMD_QUAD_IN_PAGE_PROGRAM,
    CMD_ERASE_64K_BLOCK,
    CMD_OP_SUSPEND,
    CMD_OP_RESUME,
    CMD_SET_WRITE_LATCH,
    CMD_CLEAR_WRITE_LATCH,
    CMD_VOLATILE_STATUS_WRITE_ENABLE,
    CMD_SINGLE_BLOCK_LOCK,
    CMD_SINGLE_BLOCK_UNLOCK,
    CMD_BLOCK_LOCK_QUERY,
    CMD_ALL_BLOCKS_LOCK,
    CMD_ALL_BLOCKS_UNLOCK,
    CMD_SECURE_AREA_ERASE,
    CMD_SECURE_AREA_PROGRAM
  } fpc_cmd_t;

  typedef struct packed {
    fpc_cmd_t cmd;
    logic alt_opcode;
    logic [23:0] addr;
  } fpc_req_t;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } fpc_pins_t;

  // ****************************************
  // command decoding
  // ****************************************
  function automatic logic [7:0] fpc_opcode(input fpc_cmd_t c, input logic alt);
    case (c)
      CMD_PAGE_PROGRAM: fpc_opcode = OPC_PAGE_PROGRAM;
      CMD_DUAL_IN_PAGE_PROGRAM: fpc_opcode = OPC_DUAL_IN_PAGE_PROGRAM;
      CMD_QUAD_IN_PAGE_PROGRAM: fpc_opcode = OPC_QUAD_IN_PAGE_PROGRAM;
      CMD_ERASE_64K_BLOCK: fpc_opcode = OPC_ERASE_64K_BLOCK;
      CMD_OP_SUSPEND: fpc_opcode = alt ? OPC_OP_SUSPEND_ALT : OPC_OP_SUSPEND;
      CMD_OP_RESUME: fpc_opcode = alt ? OPC_OP_RESUME_ALT : OPC_OP_RESUME;
      CMD_SET_WRITE_LATCH: fpc_opcode = OPC_SET_WRITE_LATCH;
      CMD_CLEAR_WRITE_LATCH: fpc_opcode = OPC_CLEAR_WRITE_LATCH;
      CMD_VOLATILE_STATUS_WRITE_ENABLE: fpc_opcode = OPC_VOLATILE_STATUS_WRITE_ENABLE;
      CMD_SINGLE_BLOCK_LOCK: fpc_opcode = OPC_SINGLE_BLOCK_LOCK;
      CMD_SINGLE_BLOCK_UNLOCK: fpc_opcode = OPC_SINGLE_BLOCK_UNLOCK;
      CMD_BLOCK_LOCK_QUERY: fpc_opcode = alt ? OPC_BLOCK_LOCK_QUERY_ALT : OPC_BLOCK_LOCK_QUERY;
      CMD_ALL_BLOCKS_LOCK: fpc_opcode = OPC_ALL_BLOCKS_LOCK;
      CMD_ALL_BLOCKS_UNLOCK: fpc_opcode = OPC_ALL_BLOCKS_UNLOCK;
      CMD_SECURE_AREA_ERASE: fpc_opcode = OPC_SECURE_AREA_ERASE;
      CMD_SECURE_AREA_PROGRAM: fpc_opcode = OPC_SECURE_AREA_PROGRAM;
      default: fpc_opcode = OPC_CLEAR_WRITE_LATCH;
    endcase
  endfunction

  function automatic logic fpc_has_addr(input fpc_cmd_t c);
    case (c)
      CMD_OP_SUSPEND, CMD_OP_RESUME, CMD_SET_WRITE_LATCH, CMD_CLEAR_WRITE_LATCH,
      CMD_VOLATILE_STATUS_WRITE_ENABLE, CMD_ALL_BLOCKS_LOCK, CMD_ALL_BLOCKS_UNLOCK:
        fpc_has_addr = 1'b0;
      default: fpc_has_addr = 1'b1;
    endcase
  endfunction

  function automatic logic fpc_has_data(input fpc_cmd_t c);
    case (c)
      CMD_PAGE_PROGRAM, CMD_DUAL_IN_PAGE_PROGRAM, CMD_QUAD_IN_PAGE_PROGRAM,
      CMD_SECURE_AREA_PROGRAM:
        fpc_has_data = 1'b1;
      default: fpc_has_data = 1'b0;
    endcase
  endfunction

  // data lanes used in the data phase: 1, 2 or 4
  function automatic logic [2:0] fpc_data_lanes(input fpc_cmd_t c);
    case (c)
      CMD_DUAL_IN_PAGE_PROGRAM: fpc_data_lanes = 3'h2;
      CMD_QUAD_IN_PAGE_PROGRAM: fpc_data_lanes = 3'h4;
      default: fpc_data_lanes = 3'h1;
    endcase
  endfunction

  function automatic logic [3:0] fpc_lane_mask(input logic [2:0] lanes);
    case (lanes)
      3'h2: fpc_lane_mask = 4'h3;
      3'h4: fpc_lane_mask = 4'hF;
      default: fpc_lane_mask = 4'h1;
    endcase
  endfunction

endpackage

/* rtl/fpc_sck_gen.sv */
// serial clock divider: makes the bus clock and marks its edges
module fpc_sck_gen #(
  parameter int HALF_CYCLES = fpc_pkg::SCK_HALF_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic sck_o,
  output logic rise_o,
  output logic fall_o
);

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  logic [7:0] cnt;
  logic toggle;

  assign toggle = run_i && (cnt == HALF_LAST);
  assign rise_o = toggle && !sck_o;
  assign fall_o = toggle && sck_o;

  // ****************************************
  // divider
  // ****************************************
  // stopping only ever happens after a fall, so the clock idles low
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 8'h00;
    end else if (!run_i || toggle) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_o <= 1'b0;
    end else if (toggle) begin
      sck_o <= !sck_o;
    end
  end

endmodule

/* rtl/fpc_shifter.sv */
// byte shifter: sends a byte msb first over 1, 2 or 4 lines and captures one line
module fpc_shifter (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [7:0] byte_i,
  input wire logic [2:0] lanes_i,
  input wire logic shift_i,
  input wire logic sample_i,
  input wire logic sin_i,
  output logic [3:0] dout_o,
  output logic last_o,
  output logic [7:0] cap_o
);

  logic [7:0] sr;
  logic [2:0] lanes;
  logic [3:0] steps;

  assign last_o = (steps == 4'h1);

  always_comb begin
    case (lanes)
      3'h2: dout_o = {2'b00, sr[7:6]};
      3'h4: dout_o = sr[7:4];
      default: dout_o = {3'b000, sr[7]};
    endcase
  end

  // ****************************************
  // shift register
  // ****************************************
  // a load wins over a shift so the next byte follows the last fall without a gap
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sr <= 8'h00;
      lanes <= 3'h1;
      steps <= 4'h0;
    end else if (load_i) begin
      sr <= byte_i;
      lanes <= lanes_i;
      steps <= 4'(8 / lanes_i);
    end else if (shift_i && steps != 4'h0) begin
      sr <= 8'(sr << lanes);
      steps <= steps - 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_o <= 8'h00;
    end else if (sample_i) begin
      cap_o <= {cap_o[6:0], sin_i};
    end
  end

endmodule

/* rtl/fpc_host.sv */
// host controller that issues program, erase, suspend, latch and lock commands to a serial flash

// Functional notes
// RULE1: page program sends 02h, three address bytes, then data bytes on one line
// RULE2: dual-input page program sends A2h, address on one line, data on two
// RULE3: quad page program sends 32h, address on one line, data on four
// RULE4: 64K block erase sends D8h with three address bytes, no data
// RULE5: suspend sends 75h or B0h alone, no address or data
// RULE6: resume sends 7Ah or 30h alone, no address or data
// RULE7: device sets its write enable latch on opcode 06h alone
// RULE8: device clears its write enable latch on opcode 04h alone
// RULE9: opcode 50h alone enables writing the volatile status register copy
// RULE10: block lock sends 36h with three address bytes, no data
// RULE11: block unlock sends 39h with three address bytes, no data
// RULE12: lock query sends 3Ch or 3Dh with address, then reads lock state
// RULE13: device locks every block on opcode 7Eh alone
// RULE14: device unlocks every block on opcode 98h alone
// RULE15: secure area erase sends 44h with three address bytes, no data
// RULE16: secure area program sends 42h, three address bytes, then data bytes
// RULE17: device ignores write commands unless its write enable latch is set
// RULE18: opcode first, address msb first, then data, all in one select
module fpc_host #(
  parameter int SCK_HALF = fpc_pkg::SCK_HALF_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire fpc_pkg::fpc_req_t req_i,
  output logic req_ready_o,
  input wire logic data_valid_i,
  input wire logic [7:0] data_i,
  input wire logic data_last_i,
  output logic data_ready_o,
  output logic done_o,
  output logic [7:0] lock_byte_o,
  output logic busy_o,
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  input wire logic [3:0] io_i
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_HOLD,
    ST_GAP
  } fpc_state_t;

  fpc_state_t state;
  fpc_state_t next_state;
  fpc_pkg::fpc_req_t req;
  logic [1:0] addr_idx;
  logic [3:0] wait_cnt;
  logic need_byte;
  logic last_byte;
  logic [3:0] io_meta;
  logic [3:0] io_sync;

  logic sck_run;
  logic sck_rise;
  logic sck_fall;
  logic sh_load;
  logic [7:0] sh_byte;
  logic [2:0] sh_lanes;
  logic sh_last;
  logic [7:0] sh_cap;
  logic byte_done;
  logic take_data;
  logic [3:0] data_mask;
  logic [3:0] sh_dout;
  fpc_pkg::fpc_pins_t pins;

  // ****************************************
  // pin input synchroniser
  // ****************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_meta <= 4'h0;
      io_sync <= 4'h0;
    end else begin
      io_meta <= io_i;
      io_sync <= io_meta;
    end
  end

  // ****************************************
  // serial clock and byte shifter
  // ****************************************
  fpc_sck_gen #(
    .HALF_CYCLES(SCK_HALF)
  ) u_sck (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .run_i(sck_run),
    .sck_o(sck_o),
    .rise_o(sck_rise),
    .fall_o(sck_fall)
  );

  // read data is sampled at our fall: the device moved it a whole period earlier
  fpc_shifter u_shift (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .load_i(sh_load),
    .byte_i(sh_byte),
    .lanes_i(sh_lanes),
    .shift_i(sck_fall),
    .sample_i(sck_fall && state == ST_READ),
    .sin_i(io_sync[1]),
    .dout_o(sh_dout),
    .last_o(sh_last),
    .cap_o(sh_cap)
  );

  assign byte_done = sck_fall && sh_last;
  assign take_data = (state == ST_DATA) && need_byte && data_valid_i;
  assign data_mask = fpc_pkg::fpc_lane_mask(fpc_pkg::fpc_data_lanes(req.cmd));

  // ****************************************
  // handshakes and pin drive
  // ****************************************
  assign req_ready_o = (state == ST_IDLE);
  assign data_ready_o = (state == ST_DATA) && need_byte;
  assign busy_o = (state != ST_IDLE);
  assign io_o = pins.dout;
  assign io_oe_o = pins.oe;

  // clock only runs while a byte is in flight; a data stall parks it low
  always_comb begin
    case (state)
      ST_OPCODE, ST_ADDR, ST_READ: sck_run = 1'b1;
      ST_DATA: sck_run = !need_byte;
      default: sck_run = 1'b0;
    endcase
  end

  always_comb begin
    pins.dout = sh_dout;
    case (state)
      ST_OPCODE, ST_ADDR: pins.oe = 4'h1; // RULE18
      ST_DATA: pins.oe = data_mask; // RULE2 RULE3
      default: pins.oe = 4'h0;
    endcase
  end

  // ****************************************
  // byte sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    sh_load = 1'b0;
    sh_byte = 8'h00;
    sh_lanes = 3'h1;
    case (state)
      ST_IDLE: begin
        if (req_valid_i) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (wait_cnt == fpc_pkg::CS_SETUP_CYCLES) begin
          sh_load = 1'b1;
          sh_byte = fpc_pkg::fpc_opcode(req.cmd, req.alt_opcode); // RULE1 RULE4 RULE9
          next_state = ST_OPCODE;
        end
      end
      ST_OPCODE: begin
        if (byte_done) begin
          if (fpc_pkg::fpc_has_addr(req.cmd)) begin
            sh_load = 1'b1;
            sh_byte = req.addr[23:16]; // RULE18
            next_state = ST_ADDR;
          end else begin
            next_state = ST_HOLD; // RULE5 RULE6
          end
        end
      end
      ST_ADDR: begin
        if (byte_done) begin
          if (addr_idx == 2'(fpc_pkg::ADDR_BYTES - 1)) begin
            if (fpc_pkg::fpc_has_data(req.cmd)) begin
              next_state = ST_DATA; // RULE16
            end else if (req.cmd == fpc_pkg::CMD_BLOCK_LOCK_QUERY) begin
              sh_load = 1'b1;
              next_state = ST_READ; // RULE12
            end else begin
              next_state = ST_HOLD; // RULE10 RULE11 RULE15
            end
          end else begin
            sh_load = 1'b1;
            sh_byte = (addr_idx == 2'h0) ? req.addr[15:8] : req.addr[7:0]; // RULE18
          end
        end
      end
      ST_DATA: begin
        if (take_data) begin
          sh_load = 1'b1;
          sh_byte = data_i;
          sh_lanes = fpc_pkg::fpc_data_lanes(req.cmd); // RULE1 RULE2 RULE3
        end else if (byte_done && last_byte) begin
          next_state = ST_HOLD;
        end
      end
      ST_READ: begin
        if (byte_done) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (wait_cnt == fpc_pkg::CS_HOLD_CYCLES) begin
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (wait_cnt == fpc_pkg::CS_GAP_CYCLES) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // request capture and counters
  // ****************************************
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req <= '0;
    end else if (state == ST_IDLE && req_valid_i) begin
      req <= req_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_cnt <= 4'h0;
    end else if (next_state != state) begin
      wait_cnt <= 4'h0;
    end else if (state == ST_SETUP || state == ST_HOLD || state == ST_GAP) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_idx <= 2'h0;
    end else if (state == ST_OPCODE) begin
      addr_idx <= 2'h0;
    end else if (state == ST_ADDR && byte_done) begin
      addr_idx <= addr_idx + 2'h1;
    end
  end

  // the data stream is paced by the user; the frame waits for each byte
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      need_byte <= 1'b0;
      last_byte <= 1'b0;
    end else if (state == ST_ADDR) begin
      need_byte <= 1'b1;
      last_byte <= 1'b0;
    end else if (take_data) begin
      need_byte <= 1'b0;
      last_byte <= data_last_i;
    end else if (state == ST_DATA && byte_done && !last_byte) begin
      need_byte <= 1'b1;
    end
  end

  // ****************************************
  // select, result and completion
  // ****************************************
  // the whole command lives inside one select so the device sees it as one unit
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_n_o <= 1'b1;
    end else if (state == ST_IDLE && req_valid_i) begin
      cs_n_o <= 1'b0; // RULE18
    end else if (state == ST_HOLD && next_state == ST_GAP) begin
      cs_n_o <= 1'b1;
    end
  end

  // the last sampled bit is merged here, since the shifter register lags a cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_byte_o <= fpc_pkg::LOCK_BYTE_RESET;
    end else if (state == ST_READ && byte_done) begin
      lock_byte_o <= {sh_cap[6:0], io_sync[1]}; // RULE12
    end
  end

  // completion only means the frame was sent; a write the device refused
  // for want of its write enable latch still reports done
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (state == ST_GAP) && (next_state == ST_IDLE); // RULE17
    end
  end

endmodule

/* verification/fpc_host_sva.sv */
// checker: port timing relations of the flash command host
module fpc_host_sva #(
  parameter int SCK_HALF = 4
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic data_valid_i,
  input wire logic data_ready_o,
  input wire logic done_o,
  input wire logic [7:0] lock_byte_o,
  input wire logic busy_o,
  input wire logic cs_n_o,
  input wire logic sck_o,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  int hi_cnt;
  // high time of the bus clock, so the high half of the period is checked exactly
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= sck_o ? hi_cnt + 1 : 0;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_take;
    req_valid_i && req_ready_o;
  endsequence
  sequence s_select;
    busy_o ##[0:2] !cs_n_o;
  endsequence
  property p_take;
    s_take |=> s_select;
  endproperty
  property p_ready_busy;
    req_ready_o != busy_o;
  endproperty
  property p_idle_pins;
    !busy_o |-> cs_n_o && io_oe_o == 4'h0 && !data_ready_o;
  endproperty
  property p_sck_parked;
    cs_n_o |-> !sck_o;
  endproperty
  property p_io_hold;
    sck_o |-> $stable(io_o) && $stable(io_oe_o);
  endproperty
  property p_sck_half;
    $fell(sck_o) |-> hi_cnt == SCK_HALF;
  endproperty
  property p_done_gap;
    done_o |-> cs_n_o && $past(cs_n_o, 6);
  endproperty
  property p_done_once;
    done_o |=> !done_o && req_ready_o;
  endproperty
  property p_stall;
    data_ready_o |-> !sck_o && !cs_n_o;
  endproperty
  property p_data_take;
    data_valid_i && data_ready_o |=> !data_ready_o [*2];
  endproperty
  property p_lock_hold;
    !busy_o |-> $stable(lock_byte_o);
  endproperty
  property p_lane_mask;
    io_oe_o != 4'h0 |-> io_oe_o inside {4'h1, 4'h3, 4'hF};
  endproperty
  a_take: assert property (p_take) else $error("request taken without select");
  a_ready_busy: assert property (p_ready_busy) else $error("ready and busy agree");
  a_idle_pins: assert property (p_idle_pins) else $error("pins active while idle");
  a_sck_parked: assert property (p_sck_parked) else $error("bus clock runs unselected");
  a_io_hold: assert property (p_io_hold) else $error("io moved while clock high");
  a_sck_half: assert property (p_sck_half) else $error("bus clock high time wrong");
  a_done_gap: assert property (p_done_gap) else $error("done before deselect gap");
  a_done_once: assert property (p_done_once) else $error("done not a single pulse");
  a_stall: assert property (p_stall) else $error("clock runs while data awaited");
  a_data_take: assert property (p_data_take) else $error("data wanted too soon");
  a_lock_hold: assert property (p_lock_hold) else $error("lock byte moved while idle");
  a_lane_mask: assert property (p_lane_mask) else $error("bad lane enable mask");
endmodule
bind fpc_host fpc_host_sva #(.SCK_HALF(SCK_HALF)) chk_u (
  .clock_i(clock_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .data_valid_i(data_valid_i), .data_ready_o(data_ready_o), .done_o(done_o),
  .lock_byte_o(lock_byte_o), .busy_o(busy_o), .cs_n_o(cs_n_o), .sck_o(sck_o),
  .io_o(io_o), .io_oe_o(io_oe_o));

/* verification/fpc_flash_model.sv */
// behavioural serial flash: decodes frames, keeps latch, locks and write count
module fpc_flash_model (
  input wire logic clock_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] op, cur, rd;
  logic [23:0] adr;
  logic [255:0] lock;
  logic wel, vwen, susp, drv1;
  logic [3:0] pat;
  logic [7:0] dq[$];
  int nrise, bp, rbit, wr_cnt;
  initial begin
    {wel, vwen, susp, drv1, op} = '0;
    lock = '0;
    wr_cnt = 0;
    pat = 4'h5;
    io_oe_o = 4'h0;
  end
  // released lines toggle so a stale level never reads as valid
  always @(posedge clock_i) pat <= ~pat;
  assign io_o = {pat[3:2], io_oe_o[1] ? drv1 : pat[1], pat[0]};
  always @(negedge cs_n_i) begin
    nrise = 0;
    bp = 0;
    rbit = 0;
    dq = {};
  end
  always @(posedge sck_i) if (!cs_n_i) begin
    if (nrise < 8) op = {op[6:0], io_i[0]};
    else if (nrise < 32) adr = {adr[22:0], io_i[0]};
    else if (op == 8'hA2) begin cur = {cur[5:0], io_i[1:0]}; bp += 2; end
    else if (op == 8'h32) begin cur = {cur[3:0], io_i}; bp += 4; end
    else begin cur = {cur[6:0], io_i[0]}; bp += 1; end
    if (bp == 8) begin dq.push_back(cur); bp = 0; end
    nrise++;
  end
  // lock state leaves msb first on io1, changed on falling clock
  always @(negedge sck_i) if (!cs_n_i && nrise >= 32 && op inside {8'h3C, 8'h3D} && rbit < 8) begin
    if (rbit == 0) rd = {7'h00, lock[adr[23:16]]};
    drv1 = rd[7 - rbit];
    io_oe_o[1] = 1'b1;
    rbit++;
  end
  always @(posedge cs_n_i) begin
    io_oe_o = 4'h0;
    case (op)
      8'h06: wel = 1'b1;
      8'h04: wel = 1'b0;
      8'h50: vwen = 1'b1;
      8'h75, 8'hB0: susp = 1'b1;
      8'h7A, 8'h30: susp = 1'b0;
      default: ;
    endcase
    // writes only take effect with the latch set; short frames are dropped, except 7Eh and 98h
    if (wel && nrise >= 32) case (op)
      8'h36: lock[adr[23:16]] = 1'b1;
      8'h39: lock[adr[23:16]] = 1'b0;
      8'h02, 8'hA2, 8'h32, 8'h42, 8'hD8, 8'h44: wr_cnt++;
      default: ;
    endcase
    if (wel && op == 8'h7E) lock = '1;
    if (wel && op == 8'h98) lock = '0;
  end
endmodule

/* verification/tb.sv */
// testbench: flash command host against the behavioural flash
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, nrst_i, req_valid_i, data_valid_i, data_last_i;
  fpc_pkg::fpc_req_t req_i;
  logic [7:0] data_i, lock_byte_o;
  logic req_ready_o, data_ready_o, done_o, busy_o, cs_n_o, sck_o;
  logic [3:0] io_o, io_oe_o, dev_io, io_w;
  logic [7:0] tx[$];
  logic [7:0] opc[16] = '{8'h02, 8'hA2, 8'h32, 8'hD8, 8'h75, 8'h7A, 8'h06, 8'h04, 8'h50,
    8'h36, 8'h39, 8'h3C, 8'h7E, 8'h98, 8'h44, 8'h42};
  int num_errors = 0;
  int total_checks = 0;
  assign io_w = (io_oe_o & io_o) | (~io_oe_o & dev_io);
  fpc_host dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .data_valid_i(data_valid_i), .data_i(data_i),
    .data_last_i(data_last_i), .data_ready_o(data_ready_o), .done_o(done_o),
    .lock_byte_o(lock_byte_o), .busy_o(busy_o), .cs_n_o(cs_n_o), .sck_o(sck_o),
    .io_o(io_o), .io_oe_o(io_oe_o), .io_i(io_w));
  fpc_flash_model dev_u (.clock_i(clock_i), .cs_n_i(cs_n_o), .sck_i(sck_o), .io_i(io_w),
    .io_o(dev_io), .io_oe_o());
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // one command; bytes in tx go out after an optional user stall
  task automatic issue(fpc_pkg::fpc_cmd_t c, logic alt, logic [23:0] a, int stall);
    int w;
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_i <= '{cmd: c, alt_opcode: alt, addr: a};
    @(negedge clock_i);
    for (w = 0; w < 50 && req_ready_o !== 1'b1; w++) @(negedge clock_i);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
    foreach (tx[i]) begin
      @(negedge clock_i);
      for (w = 0; w < 900 && data_ready_o !== 1'b1; w++) @(negedge clock_i);
      repeat (stall) @(posedge clock_i);
      @(posedge clock_i);
      data_valid_i <= 1'b1;
      data_i <= tx[i];
      data_last_i <= (i == tx.size() - 1);
      @(posedge clock_i);
      data_valid_i <= 1'b0;
    end
    @(negedge clock_i);
    for (w = 0; w < 3000 && done_o !== 1'b1; w++) @(negedge clock_i);
    chk("done", 1, done_o);
    tx = {};
  endtask
  // every command in turn, or only the alternate opcodes
  task automatic t_each(logic alt);
    int k, n;
    logic [7:0] e;
    for (k = 0; k < 16; k++) begin
      if (alt && !(k inside {4, 5, 11})) continue;
      if (k inside {0, 1, 2, 15}) tx.push_back(8'hC6 ^ 8'(k));
      n = (k inside {0, 1, 2, 15}) ? 32 + 8 / ((k == 1) ? 2 : (k == 2) ? 4 : 1) :
        (k inside {4, 5, 6, 7, 8, 12, 13}) ? 8 : (k == 11) ? 40 : 32;
      e = !alt ? opc[k] : (k == 4) ? 8'hB0 : (k == 5) ? 8'h30 : 8'h3D;
      issue(fpc_pkg::fpc_cmd_t'(k), alt, {8'(k), 16'h5AC3}, 0);
      chk("opcode", e, dev_u.op);
      chk("frame length", n, dev_u.nrise);
      if (n != 8) chk("address", {8'(k), 16'h5AC3}, dev_u.adr);
      if (n > 32 && k != 11) chk("data", 8'hC6 ^ 8'(k), dev_u.dq[0]);
      if (k == 4 || k == 5) chk("suspended", k == 4, dev_u.susp);
      if (k == 8) chk("volatile enable", 1, dev_u.vwen);
    end
  endtask
  task automatic query(logic [23:0] a, logic alt, logic [7:0] e);
    issue(fpc_pkg::CMD_BLOCK_LOCK_QUERY, alt, a, 0);
    chk("lock byte", e, lock_byte_o);
  endtask
  task automatic t_lock();
    issue(fpc_pkg::CMD_SINGLE_BLOCK_LOCK, 1'b0, 24'h120000, 0);
    query(24'h12FFFF, 1'b0, 8'h00);
    issue(fpc_pkg::CMD_SET_WRITE_LATCH, 1'b0, 24'h000000, 0);
    chk("latch", 1, dev_u.wel);
    issue(fpc_pkg::CMD_SINGLE_BLOCK_LOCK, 1'b0, 24'h120000, 0);
    query(24'h12FFFF, 1'b0, 8'h01);
    query(24'h130000, 1'b1, 8'h00);
    issue(fpc_pkg::CMD_SINGLE_BLOCK_UNLOCK, 1'b0, 24'h12ABCD, 0);
    query(24'h120000, 1'b1, 8'h00);
    issue(fpc_pkg::CMD_ALL_BLOCKS_LOCK, 1'b0, 24'h000000, 0);
    query(24'hFF0000, 1'b0, 8'h01);
    issue(fpc_pkg::CMD_ALL_BLOCKS_UNLOCK, 1'b0, 24'h000000, 0);
    query(24'hFF0000, 1'b1, 8'h00);
    issue(fpc_pkg::CMD_CLEAR_WRITE_LATCH, 1'b0, 24'h000000, 0);
    chk("latch", 0, dev_u.wel);
    issue(fpc_pkg::CMD_ALL_BLOCKS_LOCK, 1'b0, 24'h000000, 0);
    query(24'h400000, 1'b0, 8'h00);
  endtask
  // quad bytes behind a stalled user, then writes without the latch
  task automatic t_prog();
    int c;
    issue(fpc_pkg::CMD_SET_WRITE_LATCH, 1'b0, 24'h000000, 0);
    c = dev_u.wr_cnt;
    tx = '{8'h81, 8'h7E};
    issue(fpc_pkg::CMD_QUAD_IN_PAGE_PROGRAM, 1'b0, 24'h0100FF, 20);
    chk("quad bytes", 16'h817E, {dev_u.dq[0], dev_u.dq[1]});
    chk("writes", c + 1, dev_u.wr_cnt);
    issue(fpc_pkg::CMD_CLEAR_WRITE_LATCH, 1'b0, 24'h000000, 0);
    tx = '{8'h33};
    issue(fpc_pkg::CMD_PAGE_PROGRAM, 1'b0, 24'h020000, 0);
    issue(fpc_pkg::CMD_ERASE_64K_BLOCK, 1'b0, 24'h030000, 0);
    chk("writes", c + 1, dev_u.wr_cnt);
  endtask
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
  initial begin
    nrst_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    data_valid_i = 1'b0;
    data_i = 8'h00;
    data_last_i = 1'b0;
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(negedge clock_i);
    chk("idle select", 1, cs_n_o);
    chk("idle ready", 1, req_ready_o);
    chk("reset lock byte", 0, lock_byte_o);
    t_each(1'b0);
    t_each(1'b1);
    t_lock();
    t_prog();
    complete_run();
  end
endmodule
